// file: hw/pser_map.svh
// Register offsets, field positions and reset values for the PHY statistics,
// equalizer and LED routing register group.
// Assumes inclusion by bare name from files under hw/.
`ifndef PSER_MAP_SVH
`define PSER_MAP_SVH

// Register addresses (5-bit management register numbers)
`define PSER_ADDR_EOF_ERR      5'h18
`define PSER_ADDR_JABBER       5'h19
`define PSER_ADDR_EQ_CMD       5'h1A
`define PSER_ADDR_LED_CTRL     5'h1B

// Equalizer command word fields
`define PSER_OP_MSB            15
`define PSER_OP_LSB            13
`define PSER_OP_NOP            3'h0
`define PSER_OP_CFG0           3'h1
`define PSER_OP_CFG1           3'h2
`define PSER_OP_CFG2           3'h3
`define PSER_OP_STATUS         3'h4
`define PSER_OP_JITTER         3'h5
`define PSER_OP_CLOCK          3'h6
`define PSER_OP_RSVD           3'h7

// Configuration word 0 fields
`define PSER_C0_SET_ZERO       12
`define PSER_C0_HI_MSB         11
`define PSER_C0_HI_LSB         10
`define PSER_C0_LO_MSB         9
`define PSER_C0_LO_LSB         8
`define PSER_C0_SQ_FEN         7
`define PSER_C0_SQ_FVAL        6
`define PSER_C0_ZERO_FEN       4

// Configuration word 1 fields
`define PSER_C1_RATIO_MSB      10
`define PSER_C1_RATIO_LSB      9
`define PSER_C1_PRE_MSB        8
`define PSER_C1_PRE_LSB        7
`define PSER_C1_LOAD_CNT       6
`define PSER_C1_LOCK_DIS       4
`define PSER_C1_TEST           0

// Configuration word 2 fields
`define PSER_C2_BREAKDOWN      9
`define PSER_C2_CNT_SEL        8
`define PSER_C2_ADAPT_MSB      7
`define PSER_C2_ADAPT_LSB      6
`define PSER_C2_SD_FEN         5
`define PSER_C2_SD_FVAL        4
`define PSER_C2_HI_DIS         1
`define PSER_C2_LO_DIS         0

// Signal detect counter presets
`define PSER_PRESET_0          5'h10
`define PSER_PRESET_1          5'h18
`define PSER_PRESET_2          5'h1C
`define PSER_PRESET_3          5'h1F

// Reset values and counter saturation limit
`define PSER_CNT_RESET         16'h0000
`define PSER_CNT_MAX           16'hFFFF
`define PSER_LED_RESET         3'h0
`define PSER_ADAPT_RESET       2'h0

`endif

// file: hw/pser_pkg.sv
// Types shared by the PHY statistics, equalizer and LED register group.
// Assumes pser_map.svh supplies the numeric constants.
package pser_pkg;

   typedef enum logic [2:0]
   {
      PSER_OPC_NOP    = 3'b000,
      PSER_OPC_CFG0   = 3'b001,
      PSER_OPC_CFG1   = 3'b010,
      PSER_OPC_CFG2   = 3'b011,
      PSER_OPC_STATUS = 3'b100,
      PSER_OPC_JITTER = 3'b101,
      PSER_OPC_CLOCK  = 3'b110,
      PSER_OPC_RSVD   = 3'b111
   } pser_opcode_t;

   typedef enum logic [2:0]
   {
      PSER_LED_ACT_LINK  = 3'b000,
      PSER_LED_SPD_COL   = 3'b001,
      PSER_LED_SPD_LINK  = 3'b010,
      PSER_LED_ACT_COL   = 3'b011
   } pser_led_sel_t;

endpackage

// file: hw/pser_cnt_if.sv
// Event and read-clear signals between the register bank and a counter.
// Assumes one clock shared by both ends.
interface pser_cnt_if;
   logic        event_pulse;
   logic        read_clear;
   logic [15:0] count;

   modport bank
   (
      output event_pulse,
      output read_clear,
      input  count
   );

   modport counter
   (
      input  event_pulse,
      input  read_clear,
      output count
   );
endinterface

// file: hw/pser_sat_counter.sv
// Saturating 16-bit event counter that clears on read.
// Assumes event and read-clear arrive as one-cycle pulses on sys_clk.
`include "pser_map.svh"

module pser_sat_counter
(
   // Clock and control
   input  wire logic   sys_clk,
   input  wire logic   rst_n,
   input  wire logic   clk_en,
   // Bank side
   pser_cnt_if.counter cnt
);

   logic [15:0] count_reg;

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         count_reg <= `PSER_CNT_RESET;
      else if (clk_en)
      begin
         if (cnt.read_clear)
            count_reg <= cnt.event_pulse ? 16'h0001 : `PSER_CNT_RESET;
         else if (cnt.event_pulse && count_reg != `PSER_CNT_MAX)
            count_reg <= count_reg + 16'h0001;
      end
   end

   assign cnt.count = count_reg;

endmodule // pser_sat_counter

// file: hw/pser_regs.sv
// PHY statistics counters, equalizer command/status port and LED routing.
// Assumes a management interface front end presenting synchronous register
// strobes on sys_clk; PHY-side event and status inputs pass two flip-flops.
`include "pser_map.svh"

module pser_regs
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        clk_en,
   // Management register access
   input  wire logic [4:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [15:0] reg_wdata,
   output logic      [15:0] reg_rdata,
   // PHY events and status (asynchronous)
   input  wire logic        eof_error_evt,
   input  wire logic        jabber_evt,
   input  wire logic        link_status,
   input  wire logic        activity_status,
   input  wire logic        speed_status,
   input  wire logic        collision_status,
   input  wire logic [1:0]  detect_state_machine,
   input  wire logic        lock_adapt_status,
   input  wire logic        adaptive_signal_detect,
   input  wire logic        squelch_status,
   input  wire logic [26:0] jitter_value,
   input  wire logic [23:0] clock_count,
   // Equalizer configuration outputs
   output logic             set_zero_pulse,
   output logic [3:0]       coded_zero,
   output logic             zero_force_en,
   output logic [1:0]       high_thresh_sel,
   output logic [1:0]       low_thresh_sel,
   output logic             squelch_force_en,
   output logic             squelch_force_val,
   output logic [1:0]       fast_transition_ratio,
   output logic [4:0]       detect_cnt_preset,
   output logic             detect_cnt_load,
   output logic             lock_adapt_dis,
   output logic             test_mode_en,
   output logic             counter_breakdown,
   output logic             count_transitions,
   output logic [1:0]       slow_adapt_time,
   output logic             sd_force_en,
   output logic             sd_force_val,
   output logic             sd_high_dis,
   output logic             sd_low_dis,
   // LED pins
   output logic             activity_led_out,
   output logic             link_led_out
);

   // Input synchronisers: stage one feeds stage two only
   localparam int SYNC_W = 6 + 2 + 3 + 27 + 24;
   logic [SYNC_W-1:0] sync1_reg;
   logic [SYNC_W-1:0] sync2_reg;
   logic              eof_d_reg;
   logic              jab_d_reg;

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end
      else if (clk_en)
      begin
         sync1_reg <= {eof_error_evt, jabber_evt, link_status, activity_status, speed_status,
                       collision_status, detect_state_machine, lock_adapt_status,
                       adaptive_signal_detect, squelch_status, jitter_value, clock_count};
         sync2_reg <= sync1_reg;
      end
   end

   logic        eof_s;
   logic        jab_s;
   logic        link_s;
   logic        act_s;
   logic        spd_s;
   logic        col_s;
   logic [1:0]  fsm_s;
   logic        lock_s;
   logic        sd_s;
   logic        sq_s;
   logic [26:0] jit_s;
   logic [23:0] clk_s;

   assign {eof_s, jab_s, link_s, act_s, spd_s, col_s, fsm_s, lock_s, sd_s, sq_s, jit_s, clk_s} = sync2_reg;

   // Edge detect events
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         eof_d_reg <= 1'b0;
         jab_d_reg <= 1'b0;
      end
      else if (clk_en)
      begin
         eof_d_reg <= eof_s;
         jab_d_reg <= jab_s;
      end
   end

   // Statistics counters
   pser_cnt_if eof_if ();
   pser_cnt_if jab_if ();

   assign eof_if.event_pulse = eof_s & ~eof_d_reg;
   assign jab_if.event_pulse = jab_s & ~jab_d_reg;
   assign eof_if.read_clear  = reg_rd && reg_addr == `PSER_ADDR_EOF_ERR;
   assign jab_if.read_clear  = reg_rd && reg_addr == `PSER_ADDR_JABBER;

   pser_sat_counter u_eof_cnt
   (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .clk_en  (clk_en),
      .cnt     (eof_if.counter)
   );

   pser_sat_counter u_jab_cnt
   (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .clk_en  (clk_en),
      .cnt     (jab_if.counter)
   );

   // Equalizer command decode
   logic                  eq_wr;
   pser_pkg::pser_opcode_t opcode;
   logic [12:0]           operand;
   pser_pkg::pser_opcode_t last_op_reg;
   logic [1:0]            jit_sel_reg;
   logic                  clk_sel_reg;
   logic [2:0]            led_sel_reg;

   assign eq_wr   = reg_wr && reg_addr == `PSER_ADDR_EQ_CMD;
   assign opcode  = pser_pkg::pser_opcode_t'(reg_wdata[`PSER_OP_MSB:`PSER_OP_LSB]);
   assign operand = reg_wdata[12:0];

   // Word 0
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         coded_zero        <= 4'h0;
         zero_force_en     <= 1'b0;
         high_thresh_sel   <= 2'h0;
         low_thresh_sel    <= 2'h0;
         squelch_force_en  <= 1'b0;
         squelch_force_val <= 1'b0;
         set_zero_pulse    <= 1'b0;
      end
      else if (clk_en)
      begin
         set_zero_pulse <= 1'b0;
         if (eq_wr && opcode == pser_pkg::PSER_OPC_CFG0)
         begin
            set_zero_pulse    <= operand[`PSER_C0_SET_ZERO];
            coded_zero        <= operand[3:0];
            zero_force_en     <= operand[`PSER_C0_ZERO_FEN];
            high_thresh_sel   <= operand[`PSER_C0_HI_MSB:`PSER_C0_HI_LSB];
            low_thresh_sel    <= operand[`PSER_C0_LO_MSB:`PSER_C0_LO_LSB];
            squelch_force_en  <= operand[`PSER_C0_SQ_FEN];
            squelch_force_val <= operand[`PSER_C0_SQ_FVAL];
         end
      end
   end

   // Word 1
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         fast_transition_ratio <= 2'h0;
         detect_cnt_preset     <= `PSER_PRESET_0;
         detect_cnt_load       <= 1'b0;
         lock_adapt_dis        <= 1'b0;
         test_mode_en          <= 1'b0;
      end
      else if (clk_en)
      begin
         detect_cnt_load <= 1'b0;
         if (eq_wr && opcode == pser_pkg::PSER_OPC_CFG1)
         begin
            fast_transition_ratio <= operand[`PSER_C1_RATIO_MSB:`PSER_C1_RATIO_LSB];
            case (operand[`PSER_C1_PRE_MSB:`PSER_C1_PRE_LSB])
               2'h0:    detect_cnt_preset <= `PSER_PRESET_0;
               2'h1:    detect_cnt_preset <= `PSER_PRESET_1;
               2'h2:    detect_cnt_preset <= `PSER_PRESET_2;
               default: detect_cnt_preset <= `PSER_PRESET_3;
            endcase
            detect_cnt_load <= operand[`PSER_C1_LOAD_CNT];
            lock_adapt_dis  <= operand[`PSER_C1_LOCK_DIS];
            test_mode_en    <= operand[`PSER_C1_TEST];
         end
      end
   end

   // Word 2
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         counter_breakdown <= 1'b0;
         count_transitions <= 1'b0;
         slow_adapt_time   <= `PSER_ADAPT_RESET;
         sd_force_en       <= 1'b0;
         sd_force_val      <= 1'b0;
         sd_high_dis       <= 1'b0;
         sd_low_dis        <= 1'b0;
      end
      else if (clk_en)
      begin
         if (eq_wr && opcode == pser_pkg::PSER_OPC_CFG2)
         begin
            counter_breakdown <= operand[`PSER_C2_BREAKDOWN];
            count_transitions <= operand[`PSER_C2_CNT_SEL];
            slow_adapt_time   <= operand[`PSER_C2_ADAPT_MSB:`PSER_C2_ADAPT_LSB];
            sd_force_en       <= operand[`PSER_C2_SD_FEN];
            sd_force_val      <= operand[`PSER_C2_SD_FVAL];
            sd_high_dis       <= operand[`PSER_C2_HI_DIS];
            sd_low_dis        <= operand[`PSER_C2_LO_DIS];
         end
      end
   end

   // Read mode selection; NOP and reserved opcodes leave everything alone
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         last_op_reg <= pser_pkg::PSER_OPC_NOP;
         jit_sel_reg <= 2'h0;
         clk_sel_reg <= 1'b0;
      end
      else if (clk_en && eq_wr)
      begin
         case (opcode)
            pser_pkg::PSER_OPC_NOP,
            pser_pkg::PSER_OPC_RSVD:
               last_op_reg <= last_op_reg;
            pser_pkg::PSER_OPC_JITTER:
            begin
               last_op_reg <= opcode;
               jit_sel_reg <= operand[1:0];
            end
            pser_pkg::PSER_OPC_CLOCK:
            begin
               last_op_reg <= opcode;
               clk_sel_reg <= operand[0];
            end
            default:
               last_op_reg <= opcode;
         endcase
      end
   end

   // LED routing control
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         led_sel_reg <= `PSER_LED_RESET;
      else if (clk_en && reg_wr && reg_addr == `PSER_ADDR_LED_CTRL)
         led_sel_reg <= reg_wdata[2:0];
   end

   // LED pin mapping
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         activity_led_out <= 1'b0;
         link_led_out     <= 1'b0;
      end
      else if (clk_en)
      begin
         if (led_sel_reg[2])
         begin
            activity_led_out <= led_sel_reg[1];
            link_led_out     <= led_sel_reg[0];
         end
         else
         begin
            case (pser_pkg::pser_led_sel_t'(led_sel_reg))
               pser_pkg::PSER_LED_ACT_LINK:
               begin
                  activity_led_out <= act_s;
                  link_led_out     <= link_s;
               end
               pser_pkg::PSER_LED_SPD_COL:
               begin
                  activity_led_out <= spd_s;
                  link_led_out     <= col_s;
               end
               pser_pkg::PSER_LED_SPD_LINK:
               begin
                  activity_led_out <= spd_s;
                  link_led_out     <= link_s;
               end
               default:
               begin
                  activity_led_out <= act_s;
                  link_led_out     <= col_s;
               end
            endcase
         end
      end
   end

   // Equalizer read value
   logic [15:0] eq_rdata;

   always_comb
   begin
      case (last_op_reg)
         pser_pkg::PSER_OPC_STATUS:
            eq_rdata = {2'b00, 3'(last_op_reg), fast_transition_ratio, fsm_s,
                        lock_s, sd_s, sq_s, coded_zero};
         pser_pkg::PSER_OPC_JITTER:
            eq_rdata = jit_sel_reg[1] ? jit_s[26:11] :
                       (jit_sel_reg[0] ? jit_s[21:6] : jit_s[15:0]);
         pser_pkg::PSER_OPC_CLOCK:
            eq_rdata = clk_sel_reg ? clk_s[23:8] : clk_s[15:0];
         default:
            eq_rdata = 16'h0000;
      endcase
   end

   // Read data register
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         reg_rdata <= 16'h0000;
      else if (clk_en && reg_rd)
      begin
         case (reg_addr)
            `PSER_ADDR_EOF_ERR: reg_rdata <= eof_if.count;
            `PSER_ADDR_JABBER:  reg_rdata <= jab_if.count;
            `PSER_ADDR_EQ_CMD:  reg_rdata <= eq_rdata;
            `PSER_ADDR_LED_CTRL: reg_rdata <= {13'h0, led_sel_reg};
            default:            reg_rdata <= 16'h0000;
         endcase
      end
   end

endmodule // pser_regs

// file: testbench/pser_regs_properties.sv
// Concurrent checks on the statistics, equalizer and LED register group.
// Assumes binding to pser_regs; one clock, synchronous active-low reset.
module pser_regs_properties
(
   // Clock and control
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic        clk_en,
   // Register access
   input wire logic [4:0]  reg_addr,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   // Equalizer configuration
   input wire logic        set_zero_pulse,
   input wire logic [3:0]  coded_zero,
   input wire logic        zero_force_en,
   input wire logic [1:0]  high_thresh_sel,
   input wire logic [1:0]  low_thresh_sel,
   input wire logic        squelch_force_en,
   input wire logic        squelch_force_val,
   input wire logic [1:0]  fast_transition_ratio,
   input wire logic [4:0]  detect_cnt_preset,
   input wire logic        detect_cnt_load,
   input wire logic        lock_adapt_dis,
   input wire logic        test_mode_en,
   input wire logic        counter_breakdown,
   input wire logic        count_transitions,
   input wire logic [1:0]  slow_adapt_time,
   input wire logic        sd_force_en,
   input wire logic        sd_force_val,
   input wire logic        sd_high_dis,
   input wire logic        sd_low_dis,
   // LED pins
   input wire logic        activity_led_out,
   input wire logic        link_led_out
);
   logic        wq;
   logic [15:0] wd;
   logic [2:0]  led_q;
   logic [2:0]  mode_q;
   wire  [2:0]  op = wd[15:13];

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // Equalizer write taken on the previous edge
   always_ff @(posedge sys_clk)
   begin
      wq <= rst_n && clk_en && reg_wr && reg_addr == 5'h1A;
      wd <= reg_wdata;
   end

   // LED select and read mode as software last wrote them
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         led_q <= 3'h0;
      else if (clk_en && reg_wr && reg_addr == 5'h1B)
         led_q <= reg_wdata[2:0];
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         mode_q <= 3'h0;
      else if (clk_en && reg_wr && reg_addr == 5'h1A && reg_wdata[15:13] inside {[3'h1:3'h6]})
         mode_q <= reg_wdata[15:13];
   end

   chk_cfg0_thresholds: assert property (wq && op == 3'h1 |-> high_thresh_sel == wd[11:10]
      && low_thresh_sel == wd[9:8]) else $error("threshold select not loaded");
   chk_cfg0_zero_squelch: assert property (wq && op == 3'h1 |-> zero_force_en == wd[4]
      && squelch_force_en == wd[7] && squelch_force_val == wd[6] && (!wd[12] || coded_zero == wd[3:0]))
      else $error("zero or squelch field not loaded");
   chk_set_zero_pulse: assert property (set_zero_pulse == (wq && op == 3'h1 && wd[12]))
      else $error("set zero pulse wrong");
   chk_cfg1_fields: assert property (wq && op == 3'h2 |-> fast_transition_ratio == wd[10:9]
      && lock_adapt_dis == wd[4] && test_mode_en == wd[0]) else $error("word 1 field not loaded");
   chk_preset_load: assert property (wq && op == 3'h2 |-> detect_cnt_load == wd[6]
      && detect_cnt_preset == (wd[8:7] == 2'h0 ? 5'h10 : wd[8:7] == 2'h1 ? 5'h18 : wd[8:7] == 2'h2 ? 5'h1C : 5'h1F))
      else $error("detect counter preset wrong");
   chk_cfg2_fields: assert property (wq && op == 3'h3 |-> slow_adapt_time == wd[7:6]
      && counter_breakdown == wd[9] && count_transitions == wd[8] && sd_force_en == wd[5]
      && sd_force_val == wd[4] && sd_high_dis == wd[1] && sd_low_dis == wd[0]) else $error("word 2 field not loaded");
   chk_nop_holds: assert property (wq && (op == 3'h0 || op == 3'h7) |-> !set_zero_pulse && !detect_cnt_load
      && $stable({coded_zero, high_thresh_sel, low_thresh_sel, fast_transition_ratio, slow_adapt_time, lock_adapt_dis}))
      else $error("ignored opcode changed configuration");
   chk_led_fixed: assert property (led_q[2] && $past(led_q) == led_q && $past(clk_en)
      |-> {activity_led_out, link_led_out} == led_q[1:0]) else $error("fixed LED code not driven");
   chk_status_cmd: assert property (reg_rd && clk_en && reg_addr == 5'h1A && mode_q == 3'h4
      |=> reg_rdata[15:11] == 5'h04) else $error("status command field wrong");

   cov_cfg1_write: cover property (wq && op == 3'h2);
   cov_led_fixed: cover property (led_q == 3'h5);
   cov_jabber_read: cover property (reg_rd && clk_en && reg_addr == 5'h19);
endmodule // pser_regs_properties

bind pser_regs pser_regs_properties u_props
(
   .sys_clk, .rst_n, .clk_en, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
   .set_zero_pulse, .coded_zero, .zero_force_en, .high_thresh_sel, .low_thresh_sel,
   .squelch_force_en, .squelch_force_val, .fast_transition_ratio, .detect_cnt_preset,
   .detect_cnt_load, .lock_adapt_dis, .test_mode_en, .counter_breakdown, .count_transitions,
   .slow_adapt_time, .sd_force_en, .sd_force_val, .sd_high_dis, .sd_low_dis,
   .activity_led_out, .link_led_out
);

// file: testbench/pser_mgmt_model.sv
// Management controller model issuing register writes and reads.
// Assumes one-cycle strobes and read data valid one cycle after the read edge.
module pser_mgmt_model
(
   // Clock
   input  wire logic        sys_clk,
   // Register access
   output logic      [4:0]  reg_addr,
   output logic             reg_wr,
   output logic             reg_rd,
   output logic      [15:0] reg_wdata,
   // Read data valid in this cycle
   output logic             rd_done
);
   timeunit 1ns;
   timeprecision 100ps;

   initial
   begin
      reg_addr  = 5'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_wdata = 16'h0000;
      rd_done   = 1'b0;
   end

   always @(posedge sys_clk)
      rd_done <= reg_rd;

   // Request held for one edge, then strobes cleared and address and data released to inverted values
   task automatic access(input logic wr, input logic [4:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= wr;
      reg_rd    <= !wr;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
   endtask
endmodule // pser_mgmt_model

// file: testbench/tb_top.sv
// Self-checking bench for the statistics, equalizer and LED register group.
// Assumes pser_regs, the management model and the bound checker.
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        clk_en = 1'b1;
   logic [4:0]  reg_addr;
   logic        reg_wr, reg_rd, rd_done, act_led, link_led;
   logic [15:0] reg_wdata, reg_rdata, d;
   logic [15:0] rnd = 16'h2231;
   logic        eof_l = 1'b0, jab_l = 1'b0, link_s = 1'b0, act_s = 1'b0, spd_s = 1'b0, col_s = 1'b0;
   logic        lock_s = 1'b0, sd_s = 1'b0, sq_s = 1'b0;
   logic [1:0]  dsm = 2'h0, ratio_exp, e;
   logic [3:0]  cz_exp;
   logic [4:0]  preset;
   logic [26:0] jit = 27'h0;
   logic [23:0] clkc = 24'h0;
   logic [16:0] note;
   logic [16:0] exp_q[$];
   int          mismatches = 0, check_count = 0, rd_sum = 0;

   always #4 sys_clk = ~sys_clk;

   pser_mgmt_model u_mgmt (.sys_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .rd_done);

   pser_regs uut
   (
      .sys_clk, .rst_n, .clk_en, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
      .eof_error_evt(eof_l), .jabber_evt(jab_l), .link_status(link_s), .activity_status(act_s),
      .speed_status(spd_s), .collision_status(col_s), .detect_state_machine(dsm),
      .lock_adapt_status(lock_s), .adaptive_signal_detect(sd_s), .squelch_status(sq_s),
      .jitter_value(jit), .clock_count(clkc), .set_zero_pulse(), .coded_zero(), .zero_force_en(),
      .high_thresh_sel(), .low_thresh_sel(), .squelch_force_en(), .squelch_force_val(),
      .fast_transition_ratio(), .detect_cnt_preset(preset), .detect_cnt_load(), .lock_adapt_dis(),
      .test_mode_en(), .counter_breakdown(), .count_transitions(), .slow_adapt_time(), .sd_force_en(),
      .sd_force_val(), .sd_high_dis(), .sd_low_dis(), .activity_led_out(act_led), .link_led_out(link_led)
   );

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] expv);
      check_count++;
      if (seen !== expv)
      begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", name, expv, seen);
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [15:0] v);
      u_mgmt.access(1'b1, a, v);
   endtask

   // Notes the expected data; acc marks a read summed instead of compared
   task automatic rd(input logic [4:0] a, input logic [15:0] v, input logic acc);
      exp_q.push_back({acc, v});
      u_mgmt.access(1'b0, a, 16'h0000);
   endtask

   task automatic pulse_n(input logic j, input int n);
      repeat (n)
      begin
         @(posedge sys_clk);
         if (j) jab_l <= 1'b1; else eof_l <= 1'b1;
         @(posedge sys_clk);
         if (j) jab_l <= 1'b0; else eof_l <= 1'b0;
      end
   endtask

   task automatic led_case(input logic [15:0] v);
      @(posedge sys_clk);
      rnd = lfsr(rnd);
      {col_s, spd_s, link_s, act_s} <= rnd[3:0];
      wr(5'h1B, v);
      repeat (6) @(posedge sys_clk);
      case (v[2:0])
         3'h0: e = {rnd[0], rnd[1]};
         3'h1: e = {rnd[2], rnd[3]};
         3'h2: e = {rnd[2], rnd[1]};
         3'h3: e = {rnd[0], rnd[3]};
         default: e = v[1:0];
      endcase
      @(negedge sys_clk);
      check("led pins", {14'h0, act_led, link_led}, {14'h0, e});
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Read results compared against the oldest note, or summed when that note carries acc
   always @(negedge sys_clk)
   begin
      if (rd_done === 1'b1)
      begin
         note = exp_q.pop_front();
         if (note[16])
            rd_sum += reg_rdata;
         else
            check("reg_rdata", reg_rdata, note[15:0]);
      end
   end

   initial
   begin
      repeat (5000) @(posedge sys_clk);
      mismatches++;
      summarize();
   end

   initial
   begin
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(negedge sys_clk);
      check("preset", {11'h0, preset}, 16'h0010);
      rd(5'h18, 16'h0000, 1'b0);
      rd(5'h19, 16'h0000, 1'b0);
      rd(5'h1A, 16'h0000, 1'b0);
      fork
         pulse_n(1'b0, 5);
         pulse_n(1'b1, 9);
      join
      repeat (6) @(posedge sys_clk);
      rd(5'h18, 16'h0005, 1'b0);
      rd(5'h19, 16'h0009, 1'b0);
      rd(5'h18, 16'h0000, 1'b0);
      rd(5'h19, 16'h0000, 1'b0);
      // Reads racing with events
      fork
         pulse_n(1'b0, 40);
         repeat (40) rd(5'h18, 16'h0000, 1'b1);
      join
      repeat (6) @(posedge sys_clk);
      rd(5'h18, 16'h0000, 1'b1);
      repeat (3) @(posedge sys_clk);
      check("eof total", rd_sum[15:0], 16'h0028);
      // Every opcode with random operands
      for (int i = 0; i < 24; i++)
      begin
         rnd = lfsr(rnd);
         d = {i[2:0], rnd[12:0]};
         if (i[2:0] == 3'h1) d[12] = 1'b1;
         if (i[2:0] == 3'h1) cz_exp = d[3:0];
         if (i[2:0] == 3'h2) ratio_exp = d[10:9];
         wr(5'h1A, d);
      end
      @(posedge sys_clk);
      rnd = lfsr(rnd);
      {dsm, lock_s, sd_s, sq_s} <= rnd[4:0];
      jit <= {rnd[10:0], rnd ^ 16'h5A5A};
      clkc <= {rnd[7:0], ~rnd};
      repeat (4) @(posedge sys_clk);
      wr(5'h1A, 16'h8000);
      rd(5'h1A, {2'h0, 3'h4, ratio_exp, rnd[4:0], cz_exp}, 1'b0);
      for (int s = 0; s < 4; s++)
      begin
         wr(5'h1A, {3'h5, 11'h0, s[1:0]});
         rd(5'h1A, s == 0 ? jit[15:0] : s == 1 ? jit[21:6] : jit[26:11], 1'b0);
      end
      for (int s = 0; s < 2; s++)
      begin
         wr(5'h1A, {3'h6, 12'h0, s[0]});
         rd(5'h1A, s == 0 ? clkc[15:0] : clkc[23:8], 1'b0);
      end
      // Unmapped addresses read zero
      wr(5'h05, 16'hFFFF);
      rd(5'h05, 16'h0000, 1'b0);
      rd(5'h1F, 16'h0000, 1'b0);
      for (int c = 0; c < 8; c++)
      begin
         rnd = lfsr(rnd);
         led_case({rnd[15:3], c[2:0]});
      end
      // Clock enable low drops a write
      wr(5'h1B, 16'h0007);
      @(posedge sys_clk);
      clk_en <= 1'b0;
      wr(5'h1B, 16'h0004);
      @(posedge sys_clk);
      clk_en <= 1'b1;
      repeat (6) @(posedge sys_clk);
      @(negedge sys_clk);
      check("led frozen", {14'h0, act_led, link_led}, 16'h0003);
      check("pending reads", 16'(exp_q.size()), 16'h0000);
      summarize();
   end
endmodule // tb_top
